// File: adc_ctrl_map.vh
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// Register byte addresses
`define ADC_ADDR_CSR 8'h70
`define ADC_ADDR_RESH 8'h71
`define ADC_ADDR_RESL 8'h72

// Control/status field positions
`define ADC_CSR_EOC 7
`define ADC_CSR_SPEED 6
`define ADC_CSR_ON 5
`define ADC_CSR_RSVD 4
`define ADC_CSR_CH_HI 3
`define ADC_CSR_CH_LO 0

// Reset values
`define ADC_CSR_RESET 8'h00
`define ADC_RES_RESET 10'h000

// Converter results at the reference limits
`define ADC_FULL_SCALE 10'h3ff
`define ADC_ZERO_SCALE 10'h000

// Converter clock divider limits (converter clock = clk / (limit + 1))
`define ADC_DIV_SLOW 2'h3
`define ADC_DIV_FAST 2'h1

// Converter clock cycles per conversion
`define ADC_CONV_CYCLES 5'h0e

`endif

// File: adc_conversion_control.v
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"

module adc_conversion_control (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Power modes
  input wire halt_mode,
  input wire wait_mode,
  // Analog front end
  output reg [3:0] channel_select,
  output reg converter_power,
  output reg sample_start,
  input wire [9:0] sar_code,
  input wire above_upper_reference,
  input wire below_lower_reference
);

  ////////////////////////////////////////////////////////////////////////////////

  reg speed;
  reg converter_on;
  reg end_of_conversion;
  reg [9:0] result;
  reg [1:0] div_count;
  reg [4:0] conv_count;
  reg converting;

  wire csr_write;
  wire high_read;
  wire adc_tick;
  wire [3:0] next_channel;
  wire channel_change;
  wire active;
  wire conv_done;
  wire [1:0] div_limit;
  reg [9:0] next_result;

  // Shared address decode for reads and writes
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign csr_write = reg_write && hit(reg_addr, `ADC_ADDR_CSR);
  assign high_read = reg_read && hit(reg_addr, `ADC_ADDR_RESH);
  assign next_channel = reg_wdata[`ADC_CSR_CH_HI:`ADC_CSR_CH_LO];
  assign channel_change = csr_write && (next_channel != channel_select);
  // Wait mode is not an input to activity on purpose; conversions keep running
  assign active = converter_on && !halt_mode;
  assign div_limit = speed ? `ADC_DIV_FAST : `ADC_DIV_SLOW;
  assign adc_tick = active && (div_count == div_limit);
  assign conv_done = converting && adc_tick && (conv_count == `ADC_CONV_CYCLES - 5'h01);

  // Clamp at the references, no overflow flag
  always @* begin
    if (above_upper_reference) begin
      next_result = `ADC_FULL_SCALE;
    end else if (below_lower_reference) begin
      next_result = `ADC_ZERO_SCALE;
    end else begin
      next_result = sar_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed <= 1'b0;
      converter_on <= 1'b0;
      channel_select <= 4'h0;
    end else if (csr_write) begin
      // Bit 4 is not stored, so it always reads zero
      speed <= reg_wdata[`ADC_CSR_SPEED];
      converter_on <= reg_wdata[`ADC_CSR_ON];
      channel_select <= next_channel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock divider and conversion sequencer

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_count <= 2'h0;
      conv_count <= 5'h00;
      converting <= 1'b0;
      sample_start <= 1'b0;
      converter_power <= 1'b0;
    end else begin
      converter_power <= active;
      sample_start <= 1'b0;
      if (!active || channel_change) begin
        // Abandon partial work; the next channel starts from a clean divider
        div_count <= 2'h0;
        conv_count <= 5'h00;
        converting <= 1'b0;
      end else begin
        div_count <= adc_tick ? 2'h0 : div_count + 2'h1;
        if (!converting) begin
          converting <= 1'b1;
          conv_count <= 5'h00;
          sample_start <= 1'b1;
        end else if (adc_tick) begin
          if (conv_done) begin
            // Restart straight away for continuous mode
            conv_count <= 5'h00;
            sample_start <= 1'b1;
          end else begin
            conv_count <= conv_count + 5'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // End-of-conversion flag and result

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      end_of_conversion <= 1'b0;
      result <= `ADC_RES_RESET;
    end else begin
      // Result is not latched against partial reads
      if (conv_done && !channel_change) begin
        result <= next_result;
      end
      if (conv_done && !channel_change) begin
        end_of_conversion <= 1'b1;
      end else if (high_read || csr_write) begin
        end_of_conversion <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (hit(reg_addr, `ADC_ADDR_CSR)) begin
        reg_rdata <= {end_of_conversion, speed, converter_on, 1'b0, channel_select};
      end else if (hit(reg_addr, `ADC_ADDR_RESH)) begin
        reg_rdata <= result[9:2];
      end else if (hit(reg_addr, `ADC_ADDR_RESL)) begin
        reg_rdata <= {6'h00, result[1:0]};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: adc_conversion_control_chk.sv
`timescale 1ns/10ps
module adc_conversion_control_chk (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  // Power modes and front end
  input wire halt_mode,
  input wire wait_mode,
  input wire [3:0] channel_select,
  input wire converter_power,
  input wire sample_start,
  input wire [9:0] sar_code,
  input wire above_upper_reference,
  input wire below_lower_reference
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire csr_wr = reg_write && reg_addr == 8'h70;
  ////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_RSVD_ZERO: assert property ($past(reg_read && reg_addr == 8'h70) |-> !reg_rdata[4])
    else $error("reserved bit set");
  AST_LOW_UPPER: assert property ($past(reg_read && reg_addr == 8'h72) |-> reg_rdata[7:2] == 6'h00)
    else $error("low byte upper bits set");
  AST_HALT_OFF: assert property (halt_mode |=> !converter_power && !sample_start)
    else $error("active in halt");
  AST_START_PWR: assert property (sample_start |-> converter_power)
    else $error("start while unpowered");
  AST_OFF_WRITE: assert property (csr_wr && !reg_wdata[5] |-> ##2 !converter_power)
    else $error("power stays on");
  // A halt in the cycle after the write legitimately changes the outcome; a second write does not
  AST_ON_WRITE: assert property (csr_wr && reg_wdata[5] ##1 (!reg_write && !halt_mode) [*2]
    |-> converter_power)
    else $error("power not on");
  AST_CH_ROUTE: assert property (csr_wr ##1 !reg_write ##1 1'b1
    |-> channel_select == $past(reg_wdata[3:0], 2))
    else $error("channel mismatch");
  AST_PULSE: assert property (sample_start |=> !sample_start)
    else $error("start pulse too long");
  cover property (sample_start && channel_select == 4'h3);
  cover property (halt_mode && $past(converter_power));
  cover property ($past(reg_read && reg_addr == 8'h71));
endmodule
bind adc_conversion_control adc_conversion_control_chk u_chk (.*);

// File: adc_conversion_control_test.sv
`timescale 1ns/10ps
module adc_conversion_control_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic halt_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic above_upper_reference = 1'b0;
  logic below_lower_reference = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] d;
  logic [9:0] sar_code = 10'h2d6;
  wire [7:0] reg_rdata;
  wire [3:0] channel_select;
  wire converter_power;
  wire sample_start;
  int errors = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  adc_conversion_control u_dut (.*);
  ////////////////////////////////////////
  task end_of_test;
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input [7:0] e, input [7:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read data stands one cycle only, so it is taken mid-cycle
  task rd(input [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task rc(input [7:0] a, input [7:0] e);
    rd(a);
    chk("rdata", e, d);
  endtask
  task poll;
    d = 8'h00;
    for (int i = 0; i < 40 && d[7] !== 1'b1; i++) rd(8'h70);
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rc(8'h70, 8'h00);
    rc(8'h71, 8'h00);
    rc(8'h72, 8'h00);
    rc(8'h73, 8'h00);
    wr(8'h70, 8'hef);
    rc(8'h70, 8'h6f);
    poll;
    rc(8'h72, 8'h02);
    rc(8'h71, 8'hb5);
    rc(8'h70, 8'h6f);
    above_upper_reference <= 1'b1;
    poll;
    rc(8'h72, 8'h03);
    rc(8'h71, 8'hff);
    above_upper_reference <= 1'b0;
    below_lower_reference <= 1'b1;
    poll;
    rc(8'h72, 8'h00);
    rc(8'h71, 8'h00);
    below_lower_reference <= 1'b0;
    wait_mode <= 1'b1;
    sar_code <= 10'h135;
    repeat (60) @(posedge clk);
    rc(8'h72, 8'h01);
    rc(8'h71, 8'h4d);
    wait_mode <= 1'b0;
    poll;
    repeat (14) @(posedge clk);
    wr(8'h70, 8'h63);
    repeat (20) @(posedge clk);
    rc(8'h70, 8'h63);
    chk("channel", 8'h03, {4'h0, channel_select});
    wr(8'h70, 8'h23);
    poll;
    rc(8'h71, 8'h4d);
    repeat (30) @(posedge clk);
    rc(8'h70, 8'h23);
    poll;
    chk("csr", 8'ha3, d);
    wr(8'h70, 8'h03);
    repeat (70) @(posedge clk);
    rc(8'h70, 8'h03);
    chk("power", 8'h00, {7'h00, converter_power});
    wr(8'h70, 8'h63);
    halt_mode <= 1'b1;
    repeat (70) @(posedge clk);
    rc(8'h70, 8'h63);
    halt_mode <= 1'b0;
    poll;
    chk("csr", 8'he3, d);
    end_of_test;
  end
endmodule
